// file: inc/ptc_defs.svh
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants of the phase trim and calibration register bank
// Assumes: command codes arrive already decoded from the management port
// Notes:   included by bare name, definitions only
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - unused upper bits of each word ignore writes and read zero
// - hold signed 5-bit third phase trim in bits 9:5, apply to balance
// - hold signed 5-bit second phase trim in bits 4:0, apply to balance
// - trim fields are two's complement, 6.256 mV per step
// - bits 12:8 hold temperature offset, one degree per step, added
// - bits 7:0 hold temperature gain multiplying sensed temperature voltage
// - junction temperature equals gain/1.6 times volts plus offset
// - calibrated temperature is returned by readback command 8Dh
// - 10-bit gain in bits 9:0 scales the rail 1 phase current limit
// - sensed input divider voltage becomes input voltage for on-time, OVP
//////////////////////////////////////////////////////////////////////////////
`ifndef PTC_DEFS_SVH
`define PTC_DEFS_SVH

// command codes
`define PTC_CMD_TRIM 8'hD1
`define PTC_CMD_TCAL 8'hD2
`define PTC_CMD_SLOPE 8'hD3
`define PTC_CMD_RATIO 8'hD4
`define PTC_CMD_TEMP 8'h8D

// writable bits of each word
`define PTC_MASK_TRIM 16'h03FF
`define PTC_MASK_TCAL 16'h1FFF
`define PTC_MASK_SLOPE 16'h03FF
`define PTC_MASK_RATIO 16'h00FF

// field positions
`define PTC_TRIM3_MSB 9
`define PTC_TRIM3_LSB 5
`define PTC_TRIM2_MSB 4
`define PTC_TRIM2_LSB 0
`define PTC_TOFS_MSB 12
`define PTC_TOFS_LSB 8
`define PTC_TGAIN_MSB 7
`define PTC_TGAIN_LSB 0
`define PTC_SLOPE_MSB 9
`define PTC_RATIO_MSB 7

// reset values
`define PTC_RST_TRIM 10'h000
`define PTC_RST_TCAL 13'h0AA0
`define PTC_RST_SLOPE 10'h000
`define PTC_RST_RATIO 8'h55

// arithmetic scaling
`define PTC_VIN_SHIFT 10
`define PTC_TEMP_NUM 3'h5
`define PTC_TEMP_SHIFT 15
`define PTC_DIV_STEPS 5'h16
`define PTC_SENSE_MAX 13'h0FFF

`endif

// file: inc/ptc_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: types of the phase trim and calibration register bank
// Assumes: nothing
// Notes:   used only by scoped names
//////////////////////////////////////////////////////////////////////////////
package ptc_pkg;

   // two current-sense trims
   typedef struct packed {
      logic signed [4:0] third;
      logic signed [4:0] second;
   } ptc_trim_t;

   // temperature calibration
   typedef struct packed {
      logic [4:0] offset;
      logic [7:0] gain;
   } ptc_tcal_t;

   // whole configuration seen by the loops
   typedef struct packed {
      ptc_trim_t trim;
      ptc_tcal_t tcal;
      logic [9:0] slope;
      logic [7:0] ratio;
   } ptc_cfg_t;

   // divider sequence, gray along idle-run-done
   typedef enum logic [1:0] {
      DIV_IDLE = 2'h0,
      DIV_RUN = 2'h1,
      DIV_DONE = 2'h3
   } ptc_div_state_t;

endpackage

// file: core/ptc_vin_div.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: serial divider turning divider voltage into input voltage
// Assumes: start only while idle
// Notes:   22 steps, quotient clamps to 16 bits, zero ratio gives all ones
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "ptc_defs.svh"

module ptc_vin_div (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // request
   input wire logic start_i,
   input wire logic [21:0] dividend_i,
   input wire logic [7:0] divisor_i,
   // answer
   output logic busy_o,
   output logic done_o,
   output logic [15:0] quot_o
);

   ptc_pkg::ptc_div_state_t state_reg, state_next;
   logic [21:0] dvd_reg, dvd_next;
   logic [21:0] q_reg, q_next;
   logic [8:0] rem_reg, rem_next;
   logic [7:0] div_reg, div_next;
   logic [4:0] cnt_reg, cnt_next;
   logic [15:0] quot_reg, quot_next;

   // one restoring step per cycle
   always_comb begin
      logic [8:0] sh;
      logic [21:0] qn;
      sh = {rem_reg[7:0], dvd_reg[21]};
      qn = {q_reg[20:0], 1'b0};
      state_next = state_reg;
      dvd_next = dvd_reg;
      q_next = q_reg;
      rem_next = rem_reg;
      div_next = div_reg;
      cnt_next = cnt_reg;
      quot_next = quot_reg;
      case (state_reg)
         ptc_pkg::DIV_IDLE: begin
            if (start_i) begin
               dvd_next = dividend_i;
               div_next = divisor_i;
               q_next = 22'h000000;
               rem_next = 9'h000;
               cnt_next = 5'h00;
               state_next = ptc_pkg::DIV_RUN;
            end
         end
         ptc_pkg::DIV_RUN: begin
            if (sh >= {1'b0, div_reg}) begin
               rem_next = sh - {1'b0, div_reg};
               qn[0] = 1'b1;
            end else begin
               rem_next = sh;
            end
            q_next = qn;
            dvd_next = {dvd_reg[20:0], 1'b0};
            cnt_next = cnt_reg + 5'h01;
            if (cnt_reg == `PTC_DIV_STEPS - 5'h01) begin
               quot_next = (qn[21:16] != 6'h00) ? 16'hFFFF : qn[15:0];
               state_next = ptc_pkg::DIV_DONE;
            end
         end
         ptc_pkg::DIV_DONE: begin
            state_next = ptc_pkg::DIV_IDLE;
         end
         default: begin
            state_next = ptc_pkg::DIV_IDLE;
         end
      endcase
   end

   // register the step
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         state_reg <= ptc_pkg::DIV_IDLE;
         dvd_reg <= 22'h000000;
         q_reg <= 22'h000000;
         rem_reg <= 9'h000;
         div_reg <= 8'h00;
         cnt_reg <= 5'h00;
         quot_reg <= 16'h0000;
      end else begin
         state_reg <= state_next;
         dvd_reg <= dvd_next;
         q_reg <= q_next;
         rem_reg <= rem_next;
         div_reg <= div_next;
         cnt_reg <= cnt_next;
         quot_reg <= quot_next;
      end
   end

   // handshake outputs
   assign busy_o = (state_reg != ptc_pkg::DIV_IDLE);
   assign done_o = (state_reg == ptc_pkg::DIV_DONE);
   assign quot_o = quot_reg;

endmodule // ptc_vin_div

// file: core/ptc_regs.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: phase trim and calibration words with their datapaths
// Assumes: management port front end delivers decoded command strobes
// Notes:   sense samples share clk_i; trim step equals one sense code step
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "ptc_defs.svh"

module ptc_regs (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // command port
   input wire logic [7:0] cmd_code_i,
   input wire logic cmd_wr_i,
   input wire logic cmd_rd_i,
   input wire logic [15:0] cmd_wdata_i,
   output logic [15:0] cmd_rdata_o,
   output logic cmd_rvalid_o,
   output logic cmd_unsup_o,
   // current balance loop
   input wire logic sense_valid_i,
   input wire logic [11:0] third_phase_sense_i,
   input wire logic [11:0] second_phase_sense_i,
   output logic [11:0] third_phase_bal_o,
   output logic [11:0] second_phase_bal_o,
   // temperature
   input wire logic thermal_valid_i,
   input wire logic [11:0] thermal_sense_input_i,
   output logic [8:0] junction_temp_o,
   // phase overcurrent
   input wire logic [7:0] ocp_setting_i,
   output logic [17:0] per_phase_overcurrent_o,
   // input voltage
   input wire logic input_sense_valid_i,
   input wire logic [11:0] input_sense_pin_i,
   input wire logic [15:0] vin_ovp_level_i,
   output logic [15:0] vin_o,
   output logic vin_valid_o,
   output logic vin_ovp_o,
   // configuration view
   output ptc_pkg::ptc_cfg_t cfg_o
);

   //////////////////////////////////////////////////////////////////////////
   // decode helpers
   //////////////////////////////////////////////////////////////////////////

   // writable bits of a word, zero for anything not writable
   function automatic logic [15:0] wmask(input logic [7:0] code);
      case (code)
         `PTC_CMD_TRIM: wmask = `PTC_MASK_TRIM;
         `PTC_CMD_TCAL: wmask = `PTC_MASK_TCAL;
         `PTC_CMD_SLOPE: wmask = `PTC_MASK_SLOPE;
         `PTC_CMD_RATIO: wmask = `PTC_MASK_RATIO;
         default: wmask = 16'h0000;
      endcase
   endfunction

   // any code this bank answers
   function automatic logic known(input logic [7:0] code);
      known = (wmask(code) != 16'h0000) || (code == `PTC_CMD_TEMP);
   endfunction

   //////////////////////////////////////////////////////////////////////////
   // configuration words
   //////////////////////////////////////////////////////////////////////////

   ptc_pkg::ptc_cfg_t cfg_reg, cfg_next;
   logic [15:0] wd;

   // reserved bits dropped on write
   assign wd = cmd_wdata_i & wmask(cmd_code_i);

   // next configuration
   always_comb begin
      cfg_next = cfg_reg;
      if (cmd_wr_i) begin
         case (cmd_code_i)
            `PTC_CMD_TRIM: begin
               cfg_next.trim.third =
                  wd[`PTC_TRIM3_MSB:`PTC_TRIM3_LSB];
               cfg_next.trim.second =
                  wd[`PTC_TRIM2_MSB:`PTC_TRIM2_LSB];
            end
            `PTC_CMD_TCAL: begin
               cfg_next.tcal.offset =
                  wd[`PTC_TOFS_MSB:`PTC_TOFS_LSB];
               cfg_next.tcal.gain =
                  wd[`PTC_TGAIN_MSB:`PTC_TGAIN_LSB];
            end
            `PTC_CMD_SLOPE: begin
               cfg_next.slope = wd[`PTC_SLOPE_MSB:0];
            end
            `PTC_CMD_RATIO: begin
               cfg_next.ratio = wd[`PTC_RATIO_MSB:0];
            end
            default: begin
               cfg_next = cfg_reg;
            end
         endcase
      end
   end

   // register configuration
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_reg <= {`PTC_RST_TRIM, `PTC_RST_TCAL, `PTC_RST_SLOPE,
                     `PTC_RST_RATIO};
      end else begin
         cfg_reg <= cfg_next;
      end
   end

   assign cfg_o = cfg_reg;

   //////////////////////////////////////////////////////////////////////////
   // read path
   //////////////////////////////////////////////////////////////////////////

   logic [15:0] rdata_reg, rdata_next;
   logic rvalid_reg, unsup_reg, unsup_next;
   logic [8:0] temp_reg, temp_next;

   // readback, unused bits read zero
   always_comb begin
      rdata_next = rdata_reg;
      unsup_next = (cmd_rd_i || cmd_wr_i) && !known(cmd_code_i);
      if (cmd_wr_i && (cmd_code_i == `PTC_CMD_TEMP)) begin
         unsup_next = 1'b1; // readback word is not writable
      end
      if (cmd_rd_i) begin
         case (cmd_code_i)
            `PTC_CMD_TRIM: rdata_next = {6'h00, cfg_reg.trim};
            `PTC_CMD_TCAL: rdata_next = {3'h0, cfg_reg.tcal};
            `PTC_CMD_SLOPE: rdata_next = {6'h00, cfg_reg.slope};
            `PTC_CMD_RATIO: rdata_next = {8'h00, cfg_reg.ratio};
            `PTC_CMD_TEMP: rdata_next = {7'h00, temp_reg};
            default: rdata_next = 16'h0000;
         endcase
      end
   end

   // register read answer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_reg <= 16'h0000;
         rvalid_reg <= 1'b0;
         unsup_reg <= 1'b0;
      end else begin
         rdata_reg <= rdata_next;
         rvalid_reg <= cmd_rd_i;
         unsup_reg <= unsup_next;
      end
   end

   assign cmd_rdata_o = rdata_reg;
   assign cmd_rvalid_o = rvalid_reg;
   assign cmd_unsup_o = unsup_reg;

   //////////////////////////////////////////////////////////////////////////
   // current balance trims
   //////////////////////////////////////////////////////////////////////////

   logic [11:0] bal_reg [2];
   logic [11:0] bal_next [2];
   logic [11:0] sense_in [2];
   logic signed [4:0] trim_in [2];

   assign sense_in[0] = third_phase_sense_i;
   assign sense_in[1] = second_phase_sense_i;
   assign trim_in[0] = cfg_reg.trim.third;
   assign trim_in[1] = cfg_reg.trim.second;

   // signed step added to each phase, clamped to the code range
   for (genvar p = 0; p < 2; p++) begin : g_trim
      always_comb begin
         logic signed [13:0] sum;
         sum = $signed({2'h0, sense_in[p]}) + 14'(trim_in[p]);
         bal_next[p] = bal_reg[p];
         if (sense_valid_i) begin
            if (sum < 14'sh0000) begin
               bal_next[p] = 12'h000;
            end else if (sum > 14'(`PTC_SENSE_MAX)) begin
               bal_next[p] = 12'hFFF;
            end else begin
               bal_next[p] = sum[11:0];
            end
         end
      end

      always_ff @(posedge clk_i or negedge resetn_i) begin
         if (!resetn_i) begin
            bal_reg[p] <= 12'h000;
         end else begin
            bal_reg[p] <= bal_next[p];
         end
      end
   end

   assign third_phase_bal_o = bal_reg[0];
   assign second_phase_bal_o = bal_reg[1];

   //////////////////////////////////////////////////////////////////////////
   // junction temperature and phase limit
   //////////////////////////////////////////////////////////////////////////

   logic [17:0] lim_reg, lim_next;

   // gain/1.6 times volts, 12-bit code spans one volt
   always_comb begin
      logic [22:0] prod;
      prod = 23'(cfg_reg.tcal.gain * thermal_sense_input_i)
             * 23'(`PTC_TEMP_NUM);
      temp_next = temp_reg;
      if (thermal_valid_i) begin
         temp_next = 9'(prod >> `PTC_TEMP_SHIFT)
                     + 9'(cfg_reg.tcal.offset);
      end
      lim_next = 18'(cfg_reg.slope * ocp_setting_i);
   end

   // register temperature and limit
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         temp_reg <= 9'h000;
         lim_reg <= 18'h00000;
      end else begin
         temp_reg <= temp_next;
         lim_reg <= lim_next;
      end
   end

   assign junction_temp_o = temp_reg;
   assign per_phase_overcurrent_o = lim_reg;

   //////////////////////////////////////////////////////////////////////////
   // input voltage
   //////////////////////////////////////////////////////////////////////////

   logic div_busy, div_done, div_start;
   logic [15:0] div_quot;
   logic [15:0] vin_reg, vin_next;
   logic vvalid_reg, ovp_reg, ovp_next;

   // samples arriving while busy are dropped
   assign div_start = input_sense_valid_i && !div_busy;

   // code times 1024 over the programmed ratio
   ptc_vin_div u_div (
      .clk_i(clk_i),
      .resetn_i(resetn_i),
      .start_i(div_start),
      .dividend_i({input_sense_pin_i, 10'h000}),
      .divisor_i(cfg_reg.ratio),
      .busy_o(div_busy),
      .done_o(div_done),
      .quot_o(div_quot)
   );

   // latch result and compare against overvoltage level
   always_comb begin
      vin_next = vin_reg;
      ovp_next = ovp_reg;
      if (div_done) begin
         vin_next = div_quot;
         ovp_next = (div_quot > vin_ovp_level_i);
      end
   end

   // register input voltage
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         vin_reg <= 16'h0000;
         vvalid_reg <= 1'b0;
         ovp_reg <= 1'b0;
      end else begin
         vin_reg <= vin_next;
         vvalid_reg <= div_done;
         ovp_reg <= ovp_next;
      end
   end

   assign vin_o = vin_reg;
   assign vin_valid_o = vvalid_reg;
   assign vin_ovp_o = ovp_reg;

   //////////////////////////////////////////////////////////////////////////
   // checks
   //////////////////////////////////////////////////////////////////////////

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence s_vin_start;
      input_sense_valid_i && !div_busy;
   endsequence

   sequence s_vin_answer;
      ##24 vin_valid_o;
   endsequence

   chk_reserved_zero: assert property (
      cmd_rd_i && (cmd_code_i == `PTC_CMD_TRIM)
      |=> cmd_rvalid_o && (cmd_rdata_o[15:10] == 6'h00))
      else $error("trim word upper bits not zero");

   chk_ratio_upper: assert property (
      cmd_rd_i && (cmd_code_i == `PTC_CMD_RATIO)
      |=> cmd_rdata_o[15:8] == 8'h00)
      else $error("ratio word upper bits not zero");

   chk_trim_store: assert property (
      cmd_wr_i && (cmd_code_i == `PTC_CMD_TRIM)
      |=> cfg_o.trim == $past(cmd_wdata_i[9:0]))
      else $error("trim word not stored");

   chk_trim_neg: assert property (
      sense_valid_i && (cfg_o.trim.second == -5'sd16)
      && (second_phase_sense_i >= 12'h010)
      |=> second_phase_bal_o == $past(second_phase_sense_i) - 12'h010)
      else $error("negative trim step wrong");

   chk_trim_pos: assert property (
      sense_valid_i && (cfg_o.trim.third == 5'sd15)
      && (third_phase_sense_i <= 12'hFF0)
      |=> third_phase_bal_o == $past(third_phase_sense_i) + 12'h00F)
      else $error("positive trim step wrong");

   chk_temp_offset: assert property (
      thermal_valid_i && (cfg_o.tcal.gain == 8'h00)
      |=> junction_temp_o == 9'($past(cfg_o.tcal.offset)))
      else $error("temperature offset not added");

   chk_temp_gain: assert property (
      thermal_valid_i && (cfg_o.tcal.gain == 8'hA0)
      && (thermal_sense_input_i == 12'hFFF)
      |=> junction_temp_o == 9'h063 + 9'($past(cfg_o.tcal.offset)))
      else $error("temperature gain wrong");

   chk_temp_read: assert property (
      cmd_rd_i && (cmd_code_i == `PTC_CMD_TEMP)
      |=> cmd_rdata_o == {7'h00, $past(junction_temp_o)})
      else $error("temperature readback wrong");

   chk_limit_zero: assert property (
      (cfg_o.slope == 10'h000) ##1 (cfg_o.slope == 10'h000)
      |-> per_phase_overcurrent_o == 18'h00000)
      else $error("phase limit ignores gain");

   chk_vin_latency: assert property (
      s_vin_start |-> s_vin_answer)
      else $error("input voltage late");

endmodule // ptc_regs

// file: sim/tb_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: self-checking bench of the phase trim and calibration bank
// Assumes: strobes and samples are driven on the falling edge of clk_i
// Notes:   a small model of the words predicts every result of the design
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "ptc_defs.svh"

// compare one value with its prediction and count the outcome
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
   n_mismatch++; $display("unexpected %s exp %h got %h", nm, ex, got); end end

module tb_top;
   logic clk_i, resetn_i, cmd_wr_i, cmd_rd_i;
   logic [7:0] cmd_code_i, ocp_setting_i;
   logic [15:0] cmd_wdata_i, cmd_rdata_o, vin_ovp_level_i, vin_o;
   logic cmd_rvalid_o, cmd_unsup_o, sense_valid_i, thermal_valid_i;
   logic input_sense_valid_i, vin_valid_o, vin_ovp_o;
   logic [11:0] third_phase_sense_i, second_phase_sense_i, input_sense_pin_i;
   logic [11:0] third_phase_bal_o, second_phase_bal_o, thermal_sense_input_i;
   logic [8:0] junction_temp_o;
   logic [17:0] per_phase_overcurrent_o;
   ptc_pkg::ptc_cfg_t cfg_o;
   int n_mismatch, check_count, e_ocp;
   integer seed;
   logic [15:0] m_trim, m_tcal, m_slope, m_ratio, d;
   logic [8:0] m_temp;

   ptc_regs dut (.clk_i(clk_i), .resetn_i(resetn_i), .cmd_code_i(cmd_code_i),
      .cmd_wr_i(cmd_wr_i), .cmd_rd_i(cmd_rd_i), .cmd_wdata_i(cmd_wdata_i),
      .cmd_rdata_o(cmd_rdata_o), .cmd_rvalid_o(cmd_rvalid_o),
      .cmd_unsup_o(cmd_unsup_o), .sense_valid_i(sense_valid_i),
      .third_phase_sense_i(third_phase_sense_i),
      .second_phase_sense_i(second_phase_sense_i),
      .third_phase_bal_o(third_phase_bal_o),
      .second_phase_bal_o(second_phase_bal_o),
      .thermal_valid_i(thermal_valid_i),
      .thermal_sense_input_i(thermal_sense_input_i),
      .junction_temp_o(junction_temp_o), .ocp_setting_i(ocp_setting_i),
      .per_phase_overcurrent_o(per_phase_overcurrent_o),
      .input_sense_valid_i(input_sense_valid_i),
      .input_sense_pin_i(input_sense_pin_i),
      .vin_ovp_level_i(vin_ovp_level_i), .vin_o(vin_o),
      .vin_valid_o(vin_valid_o), .vin_ovp_o(vin_ovp_o), .cfg_o(cfg_o));

   //////////////////////////////////////////////////////////////////////////
   // clock of 40 ns
   initial begin
      clk_i = 1'b0;
      forever #20 clk_i = ~clk_i;
   end

   // watchdog far beyond the expected run length
   initial begin
      #(40 * 20000);
      n_mismatch++;
      wrap_up();
   end

   //////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic wrap_up();
      if (n_mismatch == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // predicted configuration view
   function automatic logic [40:0] exp_cfg();
      return {m_trim[9:0], m_tcal[12:0], m_slope[9:0], m_ratio[7:0]};
   endfunction

   // reset for four cycles, model back to its reset words
   task automatic do_reset();
      resetn_i = 1'b0;
      repeat (4) @(negedge clk_i);
      resetn_i = 1'b1;
      m_trim = 16'h0000;
      m_tcal = 16'h0AA0;
      m_slope = 16'h0000;
      m_ratio = 16'h0055;
      m_temp = 9'h000;
      `CHK("cfg_rst", exp_cfg(), cfg_o)
   endtask

   // one write strobe, model keeps only the defined bits
   task automatic wr(input logic [7:0] c, input logic [15:0] v);
      logic bad;
      @(negedge clk_i);
      cmd_code_i = c;
      cmd_wdata_i = v;
      cmd_wr_i = 1'b1;
      @(negedge clk_i);
      cmd_wr_i = 1'b0;
      bad = 1'b0;
      case (c)
         `PTC_CMD_TRIM: m_trim = v & 16'h03FF;
         `PTC_CMD_TCAL: m_tcal = v & 16'h1FFF;
         `PTC_CMD_SLOPE: m_slope = v & 16'h03FF;
         `PTC_CMD_RATIO: m_ratio = v & 16'h00FF;
         default: bad = 1'b1;
      endcase
      `CHK("wr_unsup", bad, cmd_unsup_o)
      `CHK("cfg", exp_cfg(), cfg_o)
   endtask

   // one read strobe, answer checked one cycle later
   task automatic rd(input logic [7:0] c);
      logic [15:0] e;
      logic bad;
      @(negedge clk_i);
      cmd_code_i = c;
      cmd_rd_i = 1'b1;
      @(negedge clk_i);
      cmd_rd_i = 1'b0;
      bad = 1'b0;
      case (c)
         `PTC_CMD_TRIM: e = m_trim;
         `PTC_CMD_TCAL: e = m_tcal;
         `PTC_CMD_SLOPE: e = m_slope;
         `PTC_CMD_RATIO: e = m_ratio;
         `PTC_CMD_TEMP: e = {7'h00, m_temp};
         default: begin
            e = 16'h0000;
            bad = 1'b1;
         end
      endcase
      `CHK("rvalid", 1'b1, cmd_rvalid_o)
      `CHK("rdata", e, cmd_rdata_o)
      `CHK("rd_unsup", bad, cmd_unsup_o)
   endtask

   // clamp to the 12-bit code range
   function automatic int clamp(input int v);
      return (v < 0) ? 0 : (v > 4095) ? 4095 : v;
   endfunction

   // one pair of phase samples through the balance trims
   task automatic bal(input logic [11:0] s3, input logic [11:0] s2);
      int t3, t2;
      t3 = $signed(m_trim[9:5]);
      t2 = $signed(m_trim[4:0]);
      @(negedge clk_i);
      third_phase_sense_i = s3;
      second_phase_sense_i = s2;
      sense_valid_i = 1'b1;
      @(negedge clk_i);
      sense_valid_i = 1'b0;
      `CHK("bal3", clamp(int'(s3) + t3), third_phase_bal_o)
      `CHK("bal2", clamp(int'(s2) + t2), second_phase_bal_o)
   endtask

   // one thermal sample, gain and offset applied
   task automatic tmp(input logic [11:0] code);
      int t;
      t = ((int'(m_tcal[7:0]) * int'(code) * 5) >> 15) + int'(m_tcal[12:8]);
      @(negedge clk_i);
      thermal_sense_input_i = code;
      thermal_valid_i = 1'b1;
      @(negedge clk_i);
      thermal_valid_i = 1'b0;
      m_temp = t[8:0];
      `CHK("temp", t, junction_temp_o)
   endtask

   // one input sample, a second one during the divide is dropped
   task automatic vin_run(input logic [11:0] code, input logic sel);
      int e;
      e = (m_ratio[7:0] == 8'h00) ? 65535 : (int'(code) * 1024) / m_ratio;
      if (e > 65535) begin
         e = 65535;
      end
      @(negedge clk_i);
      input_sense_pin_i = code;
      vin_ovp_level_i = sel ? 16'(e) : 16'($random(seed));
      input_sense_valid_i = 1'b1;
      for (int i = 1; i <= 24; i++) begin
         @(negedge clk_i);
         input_sense_valid_i = (i == 5);
         if (i == 5) begin
            input_sense_pin_i = ~code;
         end
         `CHK("vin_valid", (i == 24), vin_valid_o)
      end
      `CHK("vin", e, vin_o)
      `CHK("vin_ovp", (e > int'(vin_ovp_level_i)), vin_ovp_o)
      repeat (3) @(negedge clk_i);
   endtask

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      seed = 32'hB0FFCE71;
      n_mismatch = 0;
      check_count = 0;
      {cmd_wr_i, cmd_rd_i, sense_valid_i, thermal_valid_i} = 4'h0;
      input_sense_valid_i = 1'b0;
      cmd_code_i = 8'h00;
      cmd_wdata_i = 16'h0000;
      ocp_setting_i = 8'h00;
      vin_ovp_level_i = 16'h0000;
      third_phase_sense_i = 12'h000;
      second_phase_sense_i = 12'h000;
      thermal_sense_input_i = 12'h000;
      input_sense_pin_i = 12'h000;
      do_reset();
      rd(`PTC_CMD_TRIM);
      rd(`PTC_CMD_TCAL);
      rd(`PTC_CMD_SLOPE);
      rd(`PTC_CMD_RATIO);
      rd(`PTC_CMD_TEMP);
      rd(8'hD5);
      wr(8'hD5, 16'h1234);
      wr(`PTC_CMD_TEMP, 16'h00FF);
      vin_run(12'h5A3, 1'b0);
      for (int it = 0; it < 20; it++) begin
         for (int w = 0; w < 4; w++) begin
            d = (it == 0) ? 16'hFE10 : (it == 1) ? 16'hFFFF :
                (it == 2) ? 16'hAB00 : (it == 3) ? 16'hEAA0 :
                (it == 4) ? 16'hA9E5 : 16'($random(seed));
            wr(8'hD1 + 8'(w), d);
            rd(8'hD1 + 8'(w));
         end
         bal(12'h000, 12'hFFF);
         bal(12'($random(seed)), 12'($random(seed)));
         tmp((it == 1 || it == 3) ? 12'hFFF : 12'($random(seed)));
         rd(`PTC_CMD_TEMP);
         @(negedge clk_i);
         ocp_setting_i = 8'($random(seed));
         @(negedge clk_i);
         e_ocp = int'(m_slope[9:0]) * int'(ocp_setting_i);
         `CHK("ocp", e_ocp, per_phase_overcurrent_o)
         vin_run(12'($random(seed)), it[0]);
      end
      do_reset();
      rd(`PTC_CMD_TCAL);
      wrap_up();
   end
endmodule // tb_top
